// >>> design/afehp_pkg.sv
// constants and types shared by the aes3 frame encoder files
package afehp_pkg;
  localparam int REG_N = 66;
  localparam logic [7:0] REG_END = 8'(REG_N);
  localparam int REG_CTRL0 = 0;
  localparam int REG_CTRL1 = 1;
  localparam int BUF_BASE = 2;
  localparam int CH_STRIDE = 16;
  localparam int SIDE_STRIDE = 4;
  localparam int UBUF_OFS = 8;
  localparam logic [7:0] BUF_FRAMES = 8'h20;
  localparam int PRO_BIT = 0;
  localparam int C0_TIMING = 0;
  localparam int C0_MUTE = 1;
  localparam int C0_DIF_LSB = 4;
  localparam int C0_DIF_MSB = 6;
  localparam int C1_FS_LSB = 0;
  localparam int C1_FS_MSB = 3;
  localparam int C1_V_LSB = 4;
  localparam logic [7:0] CTRL0_RST = 8'h83;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CS0_RST = 8'h04;
  localparam logic [2:0] DIF_16BIT = 3'h0;
  localparam int SHORT_W = 8;
  localparam int SEL_POS = 14;
  localparam int DIR_POS = 13;
  localparam logic [1:0] DEV_SEL = 2'h3;
  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] XFER_LAST = 5'h17;
  localparam logic [7:0] FRAME_LAST = 8'hBF;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  localparam logic [4:0] DATA_FIRST = 5'h04;
  localparam int AUD_W = 24;
  localparam int AUD_LSB = 4;
  localparam int V_POS = 28;
  localparam int U_POS = 29;
  localparam int C_POS = 30;
  localparam int P_POS = 31;
  localparam logic [7:0] PRE_B = 8'hE8;
  localparam logic [7:0] PRE_M = 8'hE2;
  localparam logic [7:0] PRE_W = 8'hE4;
  localparam logic [7:0] CS_CON_FS = 8'h18;
  localparam logic [7:0] CS_PRO_RATE = 8'h06;
  localparam logic [7:0] CS_PRO_EXT = 8'h23;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_HDR = 2'h1,
    H_DATA = 2'h3,
    H_DONE = 2'h2
  } afehp_host_st_t;
endpackage

// >>> design/afehp_mem_if.sv
// link between the encoder core and its control byte memory
`timescale 1ns/1ps
interface afehp_mem_if #(parameter int N_CH = 4);
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] frame;
  logic side;
  logic [N_CH-1:0] c_bit;
  logic [N_CH-1:0] u_bit;
  logic [N_CH-1:0] pro;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  modport ctl (output wr_en, addr, wr_data, frame, side,
    input rd_data, c_bit, u_bit, pro, ctrl0, ctrl1);
  modport mem (input wr_en, addr, wr_data, frame, side,
    output rd_data, c_bit, u_bit, pro, ctrl0, ctrl1);
endinterface

// >>> design/afehp_regmem.sv
// control byte memory with host port and per-frame bit taps
`timescale 1ns/1ps
module afehp_regmem #(
  parameter int N_CH = 4
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  afehp_mem_if.mem m
);
  typedef struct packed {
    logic [afehp_pkg::REG_N-1:0][7:0] mem;
    logic [7:0] rd;
    logic [N_CH-1:0] c;
    logic [N_CH-1:0] u;
    logic [N_CH-1:0] pro;
  } afehp_mem_t;

  afehp_mem_t q;
  afehp_mem_t d;

  function automatic logic [7:0] rst_byte(input int i);
    int o;
    o = i - afehp_pkg::BUF_BASE;
    rst_byte = afehp_pkg::CTRL1_RST;
    if (i == afehp_pkg::REG_CTRL0) begin
      rst_byte = afehp_pkg::CTRL0_RST;
    end else if (o >= 0 && o % afehp_pkg::SIDE_STRIDE == 0 &&
                 o % afehp_pkg::CH_STRIDE < afehp_pkg::UBUF_OFS) begin
      rst_byte = afehp_pkg::CS0_RST;
    end
  endfunction

  always_comb begin
    int base;
    base = 0;
    d = q;
    d.rd = '0;
    if (m.addr < afehp_pkg::REG_END) begin
      d.rd = q.mem[m.addr[6:0]];
    end
    if (m.wr_en && m.addr < afehp_pkg::REG_END) begin
      d.mem[m.addr[6:0]] = m.wr_data;
    end
    for (int ch = 0; ch < N_CH; ch++) begin
      base = afehp_pkg::BUF_BASE + ch * afehp_pkg::CH_STRIDE +
             int'(m.side) * afehp_pkg::SIDE_STRIDE;
      d.pro[ch] = q.mem[base][afehp_pkg::PRO_BIT];
      base = base + int'(m.frame[4:3]);
      d.c[ch] = (m.frame < afehp_pkg::BUF_FRAMES) && q.mem[base][m.frame[2:0]];
      d.u[ch] = (m.frame < afehp_pkg::BUF_FRAMES) &&
                q.mem[base + afehp_pkg::UBUF_OFS][m.frame[2:0]];
    end
    if (!resetn_in) begin
      d = '0;
      for (int i = 0; i < afehp_pkg::REG_N; i++) begin
        d.mem[i] = rst_byte(i);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    q <= d;
  end

  assign m.rd_data = q.rd;
  assign m.c_bit = q.c;
  assign m.u_bit = q.u;
  assign m.pro = q.pro;
  assign m.ctrl0 = q.mem[afehp_pkg::REG_CTRL0];
  assign m.ctrl1 = q.mem[afehp_pkg::REG_CTRL1];

  write_store_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (m.wr_en && m.addr < afehp_pkg::REG_END)
    |=> q.mem[$past(m.addr[6:0])] == $past(m.wr_data))
    else $error("written byte not stored");
  unmapped_read_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (m.addr >= afehp_pkg::REG_END) |=> q.rd == 8'h00)
    else $error("unmapped read not zero");
endmodule

// >>> design/afehp_top.sv
// four-output aes3 frame encoder with serial host port
`timescale 1ns/1ps
// Summary of operation
// - consumer mode puts fs_code in status byte 3
// - professional byte 0 bits 7-6 from fs_code
// - professional byte 4 bits 6-3 from fs_code
// - blocks of 192 frames, two 32-bit sub-frames
// - biphase-mark coding, two states per bit
// - preamble B, M or W in bits 0-3
// - preamble patterns inverted after a high state
// - audio in bits 4-27, 16-bit zeros low
// - bit 28 is the validity flag
// - bit 29 carries one user bit
// - bit 30 carries one channel-status bit
// - bit 31 makes bits 4-31 even parity
// - 128 states per sample, no gaps
// - left in first sub-frame, right second
// - outputs grounded in reset or mute
// - host port reaches 66 control bytes
// - transfer ignored unless device select is 11
// - direction 0 reads, 1 writes
// - eight-bit index selects one control byte
// - sample at rising, drive at falling edge
// - host port active when async_select low
// - writes to 42H-FFH are discarded
// - timing reset parks counters at frame 191 bit 31, positive high
// - mute drives both output polarities low
module afehp_top #(
  parameter int N_CH = 4,
  parameter int STATE_DIV = 13
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic async_select_in,
  input wire logic chip_select_n_in,
  input wire logic ctrl_clock_in,
  input wire logic ctrl_data_in_in,
  input wire logic [N_CH-1:0][afehp_pkg::AUD_W-1:0] audio_a_in,
  input wire logic [N_CH-1:0][afehp_pkg::AUD_W-1:0] audio_b_in,
  input wire logic mono_in,
  output logic ctrl_data_out_out,
  output logic sample_req_out,
  output logic [N_CH-1:0] tx_p_out,
  output logic [N_CH-1:0] tx_n_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclk;
    afehp_pkg::afehp_host_st_t hst;
    logic [4:0] hcnt;
    logic [15:0] hdr;
    logic [7:0] dsh;
    logic [7:0] osh;
    logic ld;
    logic rd_act;
    logic dout;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdat;
    logic [7:0] div;
    logic [7:0] frame;
    logic side;
    logic [4:0] bitn;
    logic half;
    logic req;
    logic [N_CH-1:0] lvl;
    logic [N_CH-1:0] pol;
    logic [N_CH-1:0][31:0] word;
    logic [N_CH-1:0][afehp_pkg::AUD_W-1:0] smp_a;
    logic [N_CH-1:0][afehp_pkg::AUD_W-1:0] smp_b;
    logic [N_CH-1:0] txp;
    logic [N_CH-1:0] txn;
  } afehp_state_t;

  afehp_state_t q;
  afehp_state_t d;
  logic tick;
  logic run;

  afehp_mem_if #(.N_CH(N_CH)) mif ();

  afehp_regmem #(.N_CH(N_CH)) u_mem (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .m(mif.mem)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic sel_ok(input logic [15:0] h);
    sel_ok = h[afehp_pkg::SEL_POS+1:afehp_pkg::SEL_POS] == afehp_pkg::DEV_SEL;
  endfunction

  // professional rate code, byte 0 bits 7-6
  function automatic logic [1:0] pro_rate(input logic [3:0] fs);
    pro_rate = (fs[3:2] == 2'h0) ? fs[1:0] : 2'h0;
  endfunction

  // professional extended rate code, byte 4 bits 6-3
  function automatic logic [3:0] pro_ext(input logic [3:0] fs);
    case (fs)
      4'hC: pro_ext = 4'h3;
      4'hD: pro_ext = 4'h1;
      4'hE: pro_ext = 4'h2;
      default: pro_ext = fs[3] ? fs : 4'h0;
    endcase
  endfunction

  // status bit with the rate fields laid over the buffered bits
  function automatic logic cs_bit(input logic [7:0] fr, input logic pro,
                                  input logic [3:0] fs, input logic cb);
    logic [7:0] oc;
    logic [7:0] or0;
    logic [7:0] oe;
    logic [1:0] r;
    logic [3:0] e;
    oc = fr - afehp_pkg::CS_CON_FS;
    or0 = fr - afehp_pkg::CS_PRO_RATE;
    oe = fr - afehp_pkg::CS_PRO_EXT;
    r = pro_rate(fs);
    e = pro_ext(fs);
    cs_bit = cb;
    if (!pro && oc < 8'h04) begin
      cs_bit = fs[oc[1:0]];
    end
    if (pro && or0 < 8'h02) begin
      cs_bit = r[or0[0]];
    end
    if (pro && oe < 8'h04) begin
      cs_bit = e[oe[1:0]];
    end
  endfunction

  assign tick = q.div == 8'(STATE_DIV - 1);
  assign run = resetn_in && mif.ctrl0[afehp_pkg::C0_TIMING];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic nsd;
    logic nhf;
    logic [15:0] hfull;
    logic [7:0] nfr;
    logic [7:0] pat;
    logic [4:0] nbt;
    logic [2:0] k;
    logic [afehp_pkg::AUD_W-1:0] s;
    logic [31:0] w;
    d = q;
    rise = ctrl_clock_in && !q.sclk;
    fall = !ctrl_clock_in && q.sclk;
    hfull = {q.hdr[14:0], ctrl_data_in_in};
    s = '0;
    w = '0;
    nhf = !q.half;
    nbt = q.bitn + {4'h0, q.half};
    nsd = q.side ^ (q.half && q.bitn == afehp_pkg::BIT_LAST);
    nfr = q.frame;
    if (q.half && q.bitn == afehp_pkg::BIT_LAST && q.side) begin
      nfr = (q.frame == afehp_pkg::FRAME_LAST) ? 8'h00 : q.frame + 8'h01;
    end
    k = {nbt[1:0], nhf};
    pat = nsd ? afehp_pkg::PRE_W : ((nfr == 8'h00) ? afehp_pkg::PRE_B : afehp_pkg::PRE_M);

    // host port, sampled by the system clock
    d.sclk = ctrl_clock_in;
    d.wr_en = 1'b0;
    if (async_select_in || chip_select_n_in) begin
      d.hst = afehp_pkg::H_IDLE;
      d.hcnt = '0;
      d.ld = 1'b0;
      d.rd_act = 1'b0;
      d.dout = 1'b0;
    end else begin
      case (q.hst)
        afehp_pkg::H_IDLE, afehp_pkg::H_HDR: begin
          d.hst = afehp_pkg::H_HDR;
          if (rise) begin
            d.hdr = hfull;
            d.hcnt = q.hcnt + 5'h01;
            if (q.hcnt == afehp_pkg::HDR_LAST) begin
              d.hst = afehp_pkg::H_DATA;
              d.addr = hfull[7:0];
              d.ld = sel_ok(hfull) && hfull[afehp_pkg::DIR_POS] == afehp_pkg::DIR_READ;
              d.rd_act = d.ld;
            end
          end
        end
        afehp_pkg::H_DATA: begin
          if (rise) begin
            d.dsh = {q.dsh[6:0], ctrl_data_in_in};
            d.hcnt = q.hcnt + 5'h01;
            if (q.hcnt == afehp_pkg::XFER_LAST) begin
              d.hst = afehp_pkg::H_DONE;
              d.wdat = {q.dsh[6:0], ctrl_data_in_in};
              d.wr_en = sel_ok(q.hdr) && q.hdr[afehp_pkg::DIR_POS] == afehp_pkg::DIR_WRITE;
            end
          end
        end
        afehp_pkg::H_DONE: begin
          d.hst = afehp_pkg::H_DONE;
        end
        default: begin
          d.hst = afehp_pkg::H_IDLE;
        end
      endcase
      if (fall && q.ld) begin
        d.ld = 1'b0;
        d.dout = mif.rd_data[7];
        d.osh = {mif.rd_data[6:0], 1'b0};
      end else if (fall && q.rd_act && q.hst == afehp_pkg::H_DATA) begin
        d.dout = q.osh[7];
        d.osh = {q.osh[6:0], 1'b0};
      end else if (fall) begin
        d.rd_act = 1'b0;
        d.dout = 1'b0;
      end
    end

    // frame position, one step per state period
    d.div = tick ? 8'h00 : q.div + 8'h01;
    d.req = 1'b0;
    if (tick) begin
      d.half = nhf;
      d.bitn = nbt;
      d.side = nsd;
      d.frame = nfr;
      if (nbt == 5'h00 && !nhf && !nsd) begin
        d.smp_a = audio_a_in;
        d.smp_b = audio_b_in;
        d.req = 1'b1;
      end
      for (int ch = 0; ch < N_CH; ch++) begin
        if (nbt < afehp_pkg::DATA_FIRST) begin
          if (k == 3'h0) begin
            d.pol[ch] = q.lvl[ch];
          end
          d.lvl[ch] = pat[3'h7 - k] ^ ((k == 3'h0) ? q.lvl[ch] : q.pol[ch]);
        end else if (!nhf) begin
          d.lvl[ch] = !q.lvl[ch];
        end else begin
          d.lvl[ch] = q.lvl[ch] ^ q.word[ch][nbt];
        end
        if (nbt == afehp_pkg::DATA_FIRST && !nhf) begin
          s = q.smp_a[ch];
          if (q.side) begin
            s = mono_in ? '0 : q.smp_b[ch];
          end
          if (mif.ctrl0[afehp_pkg::C0_DIF_MSB:afehp_pkg::C0_DIF_LSB] ==
              afehp_pkg::DIF_16BIT) begin
            s[afehp_pkg::SHORT_W-1:0] = '0;
          end
          w = '0;
          w[afehp_pkg::AUD_LSB +: afehp_pkg::AUD_W] = s;
          w[afehp_pkg::V_POS] = mif.ctrl1[afehp_pkg::C1_V_LSB + ch];
          w[afehp_pkg::U_POS] = mif.u_bit[ch];
          w[afehp_pkg::C_POS] = cs_bit(q.frame, mif.pro[ch],
            mif.ctrl1[afehp_pkg::C1_FS_MSB:afehp_pkg::C1_FS_LSB], mif.c_bit[ch]);
          w[afehp_pkg::P_POS] = ^w[afehp_pkg::P_POS-1:afehp_pkg::AUD_LSB];
          d.word[ch] = w;
        end
      end
    end
    if (!run) begin
      d.div = 8'h00;
      d.frame = afehp_pkg::FRAME_LAST;
      d.side = 1'b1;
      d.bitn = afehp_pkg::BIT_LAST;
      d.half = 1'b1;
      d.lvl = '0;
      d.req = 1'b0;
    end

    // line outputs
    if (!resetn_in || !mif.ctrl0[afehp_pkg::C0_MUTE]) begin
      d.txp = '0;
      d.txn = '0;
    end else if (!run) begin
      d.txp = '1;
      d.txn = '0;
    end else begin
      d.txp = d.lvl;
      d.txn = ~d.lvl;
    end
    if (!resetn_in) begin
      d = '0;
      d.frame = afehp_pkg::FRAME_LAST;
      d.side = 1'b1;
      d.bitn = afehp_pkg::BIT_LAST;
      d.half = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    q <= d;
  end

  assign mif.wr_en = q.wr_en;
  assign mif.addr = q.addr;
  assign mif.wr_data = q.wdat;
  assign mif.frame = q.frame;
  assign mif.side = q.side;
  assign ctrl_data_out_out = q.dout;
  assign sample_req_out = q.req;
  assign tx_p_out = q.txp;
  assign tx_n_out = q.txn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  mute_low_a: assert property (
    !mif.ctrl0[afehp_pkg::C0_MUTE] |=> tx_p_out == '0 && tx_n_out == '0)
    else $error("mute did not ground outputs");
  timing_rst_a: assert property (
    (mif.ctrl0[afehp_pkg::C0_MUTE] && !mif.ctrl0[afehp_pkg::C0_TIMING])
    |=> tx_p_out == '1 && tx_n_out == '0 && q.frame == afehp_pkg::FRAME_LAST)
    else $error("timing reset level wrong");
  tx_pair_a: assert property (
    (mif.ctrl0[afehp_pkg::C0_MUTE] && mif.ctrl0[afehp_pkg::C0_TIMING])
    |=> tx_n_out == ~tx_p_out)
    else $error("outputs not complementary");
  frame_range_a: assert property (
    q.frame <= afehp_pkg::FRAME_LAST)
    else $error("frame counter out of range");
  gapless_a: assert property (
    (run && tick && q.half && q.bitn == afehp_pkg::BIT_LAST && q.side)
    ##1 run |-> q.bitn == 5'h00 && !q.side &&
    q.frame == (($past(q.frame) == afehp_pkg::FRAME_LAST) ? 8'h00 : $past(q.frame) + 8'h01))
    else $error("frame did not follow without gap");
  biphase_a: assert property (
    (run && tick && q.half && q.bitn >= 5'h03 && q.bitn != afehp_pkg::BIT_LAST)
    ##1 run |-> q.lvl[0] != $past(q.lvl[0]))
    else $error("bit cell did not start with a transition");
  preamble_a: assert property (
    (run && tick && q.bitn == 5'h00) ##1 run |-> q.lvl[0] == $past(q.lvl[0]))
    else $error("preamble missing its coding violation");
  parity_a: assert property (
    ^q.word[0][afehp_pkg::P_POS:afehp_pkg::AUD_LSB] == 1'b0)
    else $error("sub-frame parity odd");
  req_pos_a: assert property (
    sample_req_out |-> (!q.side && q.bitn == 5'h00 && !q.half) ##1 !sample_req_out)
    else $error("sample request off frame start");
  sel_write_a: assert property (
    q.wr_en |-> q.hdr[afehp_pkg::SEL_POS+1:afehp_pkg::SEL_POS] == afehp_pkg::DEV_SEL &&
    q.hdr[afehp_pkg::DIR_POS] == afehp_pkg::DIR_WRITE && q.hst == afehp_pkg::H_DONE)
    else $error("write without select or direction");
  dout_fall_a: assert property (
    $changed(ctrl_data_out_out) |-> ($past(q.sclk) && !q.sclk) ||
    q.hst == afehp_pkg::H_IDLE)
    else $error("data out moved off a falling edge");
  dout_idle_a: assert property (
    q.hst == afehp_pkg::H_IDLE |-> !ctrl_data_out_out)
    else $error("data out high while idle");
endmodule

// >>> tb/afehp_rx_model.sv
// behavioural line receiver that decodes one encoder output
`timescale 1ns/1ps
module afehp_rx_model #(
  parameter int DIV = 2
) (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic sync_in,
  output logic [31:0] word_out,
  output logic pol_ok_out,
  output logic bip_ok_out,
  output logic got_out
);
  // ------
  // helpers
  // ------
  function automatic logic [27:0] bits(input logic [63:0] v);
    for (int k = 4; k < 32; k++) bits[k-4] = v[63-2*k] ^ v[62-2*k];
  endfunction

  function automatic logic bip(input logic [63:0] v);
    bip = 1'b1;
    for (int k = 4; k < 32; k++) if (v[63-2*k] == v[64-2*k]) bip = 1'b0;
  endfunction

  // ------
  // state capture, one sub-frame per 64 states
  // ------
  logic [63:0] s = '0;
  logic [7:0] q;
  logic prev = 1'b0;
  logic last = 1'b0;
  int dcnt = 0;
  int st = 0;

  always @(posedge clk_in) begin
    got_out <= 1'b0;
    dcnt = dcnt + 1;
    if (sync_in === 1'b1) begin
      dcnt = DIV;
      st = 0;
    end
    if (dcnt >= DIV) begin
      dcnt = 0;
      if (st % 64 == 0) prev = last;
      last = line_in;
      s = {s[62:0], line_in};
      if (st % 64 == 63) begin
        q = s[63] ? s[63:56] : ~s[63:56];
        word_out[3:0] <= (q == 8'hE8) ? 4'h1 : (q == 8'hE2) ? 4'h2 :
          (q == 8'hE4) ? 4'h3 : 4'h0;
        pol_ok_out <= (s[63] != prev);
        bip_ok_out <= bip(s);
        word_out[31:4] <= bits(s);
        got_out <= 1'b1;
      end
      st = (st + 1) % 128;
    end
  end
endmodule

// >>> tb/afehp_top_bench.sv
// self-checking bench for the four-output aes3 frame encoder
`timescale 1ns/1ps
module afehp_top_bench;
  // ------
  // signals and instances
  // ------
  localparam int DIV = 2;
  localparam logic [23:0] AUD_A = 24'h5A3C96;
  localparam logic [23:0] AUD_B = 24'hA5C369;
  logic sys_clk;
  logic resetn;
  logic async_sel;
  logic chip_sel_n;
  logic ser_clk;
  logic cdin;
  logic mono;
  logic cdout;
  logic sreq;
  logic [3:0] tx_p;
  logic [3:0] tx_n;
  logic [3:0][23:0] aud_a;
  logic [3:0][23:0] aud_b;
  logic [31:0] word;
  logic pol_ok;
  logic bip_ok;
  logic got;
  int err_total = 0;
  int checked = 0;
  logic [7:0] r;
  logic [7:0] ri [6] = '{8'h00, 8'h01, 8'h02, 8'h36, 8'h03, 8'h41};
  logic [7:0] rv [6] = '{8'h83, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
  logic [3:0] pro_fs [2] = '{4'hC, 4'h2};

  afehp_top #(.N_CH(4), .STATE_DIV(DIV)) u_afehp_top (
    .sys_clk_in(sys_clk),
    .resetn_in(resetn),
    .async_select_in(async_sel),
    .chip_select_n_in(chip_sel_n),
    .ctrl_clock_in(ser_clk),
    .ctrl_data_in_in(cdin),
    .audio_a_in(aud_a),
    .audio_b_in(aud_b),
    .mono_in(mono),
    .ctrl_data_out_out(cdout),
    .sample_req_out(sreq),
    .tx_p_out(tx_p),
    .tx_n_out(tx_n)
  );

  afehp_rx_model #(.DIV(DIV)) u_afehp_rx_model (
    .clk_in(sys_clk),
    .line_in(tx_p[0]),
    .sync_in(sreq),
    .word_out(word),
    .pol_ok_out(pol_ok),
    .bip_ok_out(bip_ok),
    .got_out(got)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------
  // tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // host frame at 8 sys cycles per serial clock, msb first, chip select held
  task automatic xfer(input logic [1:0] sel, input logic dir, input logic [7:0] idx,
      input logic [7:0] wd, output logic [7:0] rd_v);
    logic [23:0] f;
    f = {sel, dir, 5'h00, idx, wd};
    rd_v = 8'h00;
    chip_sel_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      ser_clk <= 1'b0;
      cdin <= f[i];
      repeat (4) @(posedge sys_clk);
      if (i < 8) rd_v[i] = cdout;
      ser_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    ser_clk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(cdout, 1'b0);
    chip_sel_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    xfer(2'h3, 1'b1, idx, d, x);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    xfer(2'h3, 1'b0, idx, 8'h00, v);
  endtask

  // timing reset parks the line high, release restarts at frame 0
  task automatic restart();
    wr(8'h00, 8'h82);
    repeat (4) @(posedge sys_clk);
    check({tx_p, tx_n}, 8'hF0);
    wr(8'h00, 8'h83);
  endtask

  function automatic logic cexp(input logic [3:0] fs, input logic [7:0] b0, input int f);
    logic [1:0] rc;
    logic [3:0] ec;
    rc = (fs == 4'h1) ? 2'h1 : (fs == 4'h2) ? 2'h2 : (fs == 4'h3) ? 2'h3 : 2'h0;
    ec = !fs[3] ? 4'h0 : (fs == 4'hC) ? 4'h3 : (fs == 4'hD) ? 4'h1 :
      (fs == 4'hE) ? 4'h2 : fs;
    if (b0[0] && (f == 6 || f == 7)) return rc[f - 6];
    if (b0[0] && f >= 35 && f <= 38) return ec[f - 35];
    if (!b0[0] && f >= 24 && f <= 27) return fs[f - 24];
    return (f < 8) ? b0[f % 8] : 1'b0;
  endfunction

  task automatic wait_sub(output logic [31:0] w, output int gap);
    gap = 0;
    do begin
      @(posedge sys_clk);
      gap++;
    end while (got !== 1'b1 && gap < 2000);
    w = word;
  endtask

  // decode 40 frames from frame 0 and compare every sub-frame field
  task automatic run(input logic [3:0] fs, input logic [7:0] b0, input logic [7:0] ub,
      input logic mn);
    logic [31:0] w;
    logic [23:0] aud;
    int gap;
    int n;
    n = 0;
    do begin
      wait_sub(w, gap);
      n++;
    end while (w[3:0] !== 4'h1 && n < 4);
    for (int f = 0; f < 40; f++) begin
      for (int sd = 0; sd < 2; sd++) begin
        if (f + sd > 0) begin
          wait_sub(w, gap);
          check(32'(gap), 32'(64 * DIV));
          check(pol_ok, 1'b1);
          check(tx_n ^ tx_p, 4'hF);
        end
        aud = (sd == 1) ? (mn ? 24'h000000 : AUD_B) : AUD_A;
        check(w[3:0], (sd == 1) ? 4'h3 : (f == 0) ? 4'h1 : 4'h2);
        check(bip_ok, 1'b1);
        check(w[27:4], {aud[23:8], 8'h00});
        check(w[28], 1'b1);
        check(w[29], (sd == 0 && f < 8) ? ub[f % 8] : 1'b0);
        check(w[30], cexp(fs, (sd == 0) ? b0 : 8'h04, f));
        check(^w[31:4], 1'b0);
      end
    end
  endtask

  // ------
  // watchdog and main sequence
  // ------
  initial begin
    #(60000 * 25);
    err_total++;
    $display("Error %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    resetn <= 1'b0;
    async_sel <= 1'b0;
    chip_sel_n <= 1'b1;
    ser_clk <= 1'b0;
    cdin <= 1'b0;
    mono <= 1'b0;
    aud_a <= {4{AUD_A}};
    aud_b <= {4{AUD_B}};
    repeat (5) @(posedge sys_clk);
    check({tx_p, tx_n, cdout}, 9'h000);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      rd(ri[i], r);
      check(r, rv[i]);
    end
    wr(8'h05, 8'hA5);
    wr(8'h41, 8'h3C);
    wr(8'h42, 8'hFF);
    xfer(2'h2, 1'b1, 8'h05, 8'h5A, r);
    xfer(2'h1, 1'b0, 8'h05, 8'h00, r);
    check(r, 8'h00);
    async_sel <= 1'b1;
    wr(8'h05, 8'h11);
    rd(8'h05, r);
    check(r, 8'h00);
    async_sel <= 1'b0;
    rd(8'h05, r);
    check(r, 8'hA5);
    rd(8'h41, r);
    check(r, 8'h3C);
    rd(8'h42, r);
    check(r, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h01, 8'h1E);
    restart();
    run(4'hE, 8'h04, 8'h00, 1'b0);
    wr(8'h02, 8'h05);
    wr(8'h0A, 8'h81);
    mono <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(8'h01, {4'h1, pro_fs[i]});
      restart();
      run(pro_fs[i], 8'h05, 8'h81, 1'b1);
    end
    wr(8'h00, 8'h80);
    repeat (4) @(posedge sys_clk);
    check({tx_p, tx_n}, 8'h00);
    report_and_stop();
  end
endmodule
